// [rtl/astx_map.vh]
// Register map, field positions, reset values and timing counts of the serial transceiver
`ifndef ASTX_MAP_VH
`define ASTX_MAP_VH

`define ASTX_ADDR_W 6
`define ASTX_OFF_INTCTL 6'h00
`define ASTX_OFF_PIFLG 6'h04
`define ASTX_OFF_PIEN 6'h08
`define ASTX_OFF_PIPRI 6'h0c
`define ASTX_OFF_RXSC 6'h10
`define ASTX_OFF_TXBUF 6'h14
`define ASTX_OFF_TXSC 6'h18
`define ASTX_OFF_BAUD 6'h1c
`define ASTX_OFF_RXBUF 6'h20

`define ASTX_B_GIE 7
`define ASTX_B_PERIPHERAL_INTERRUPT_ENABLE 6
`define ASTX_B_RX_COMPLETE_FLAG 5
`define ASTX_B_TX_BUFFER_EMPTY_FLAG 4

`define ASTX_B_SERIAL_PORT_ENABLE 7
`define ASTX_B_RX9 6
`define ASTX_B_SINGLE_RECEIVE_ENABLE 5
`define ASTX_B_CONTINUOUS_RECEIVE_ENABLE 4
`define ASTX_B_ADDRESS_DETECT_ENABLE 3
`define ASTX_B_FRAMING_ERROR_FLAG 2
`define ASTX_B_OVERRUN_ERROR_FLAG 1
`define ASTX_B_RX_NINTH_BIT_VALUE 0

`define ASTX_B_CLOCK_SOURCE_SELECT 7
`define ASTX_B_TX9 6
`define ASTX_B_TRANSMIT_ENABLE 5
`define ASTX_B_SYNC 4
`define ASTX_B_HIGH_SPEED_BAUD_SELECT 2
`define ASTX_B_SHIFTER_EMPTY_STATUS 1
`define ASTX_B_TX_NINTH_BIT_VALUE 0

`define ASTX_RST_BYTE 8'h00
`define ASTX_RST_TXSC 8'h02
`define ASTX_TICKS_PER_BIT 4'hf
`define ASTX_MID_BIT 4'h7
`define ASTX_LOW_PRESCALE 2'h3
`define ASTX_BITS_8 4'h8
`define ASTX_BITS_9 4'h9

`endif

// [rtl/astx_top.v]
// Asynchronous serial transceiver with APB register access
// Functional notes
// [R1] Shift register reloads from holding buffer only after previous stop bit is sent.
// [R2] Pending word moves to shifter within one cycle; buffer-empty flag then set.
// [R3] Buffer-empty flag ignores its enable, cannot be cleared by writes, sets on load.
// [R4] Transmit interrupt enable gates the buffer-empty flag onto the interrupt request.
// [R5] Read-only shifter-empty bit shows an idle shifter; no interrupt tied to it.
// [R6] The transmit shift register has no software address.
// [R7] Setting transmit enable sets the buffer-empty flag.
// [R8] Buffer-empty flag reads cleared only from the second cycle after the write.
// [R9] Nine-bit transmit sends the ninth bit from its register bit.
// [R10] Asynchronous mode needs synchronous-select clear and serial port enable set.
// [R11] With transmit enabled, writing the holding buffer starts a transmission.
// [R12] High-speed baud select picks the faster prescale for transmit and receive.
// [R13] Receiver samples the line at sixteen times the bit rate.
// [R14] Reception runs only while continuous receive enable is set.
// [R15] Each received word sets receive-complete flag; interrupt if enabled.
// [R16] Software reads receive status before the received data register.
// [R17] Clearing continuous receive enable clears pending receive errors.
// [R18] Interrupts need both global and peripheral enable bits set.
// [R19] Receive priority bit selects the receive interrupt level.
// [R20] Address detect with nine bits drops data words; clearing it admits all.
// [R21] Synchronous master mode is half duplex.
// [R22] Synchronous select with port enabled turns pins into clock and data lines.
// [R23] Clock source select makes the device master driving the clock line.
// [R24] Frame: one start, eight or nine data bits LSB first, one stop, no parity.
// [R25] Baud generator runs at sixteen or sixty-four times bit rate.
// [R26] Asynchronous transfers halt in sleep.
// [R27] In address detect, a word with ninth bit one is loaded and flagged.
// [R28] Low stop bit sets framing error; word into full buffer sets overrun.
`timescale 1ns/10ps
`include "astx_map.vh"

module astx_top (
    input wire clk_sys,
    input wire sys_rst,
    input wire clk_en,
    input wire sleep_mode,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire tx_ck_in,
    output reg tx_ck_out,
    output reg tx_ck_oe,
    input wire rx_dt_in,
    output reg rx_dt_out,
    output reg rx_dt_oe,
    output reg irq_high,
    output reg irq_low
);

    reg [7:0] intctl;
    reg [7:0] pien;
    reg [7:0] pipri;
    reg [7:0] rxsc_ctl;
    reg [7:0] txsc_ctl;
    reg [7:0] baud;
    reg [7:0] txbuf;
    reg [7:0] rxbuf;
    reg rx_ninth_bit_value;
    reg framing_error_flag;
    reg overrun_error_flag;
    reg tx_buffer_empty_flag;
    reg rx_complete_flag;
    reg txbuf_full;
    reg tx_buffer_empty_flag_clr_pend;
    reg [10:0] tx_shift_register;
    reg [3:0] tx_bits;
    reg [3:0] tx_tick;
    reg tx_busy;
    reg [7:0] brg_cnt;
    reg [1:0] pre_cnt;
    reg samp_tick;
    reg [2:0] rx_sync;
    reg rx_level;
    reg [3:0] rx_tick;
    reg [3:0] rx_bits;
    reg [8:0] rx_shift;
    reg [2:0] rx_state;
    reg [31:0] next_rdata;
    reg next_err;

    localparam [2:0] RX_IDLE = 3'b001;
    localparam [2:0] RX_DATA = 3'b010;
    localparam [2:0] RX_STOP = 3'b100;

    wire serial_port_enable = rxsc_ctl[`ASTX_B_SERIAL_PORT_ENABLE];
    wire sync_sel = txsc_ctl[`ASTX_B_SYNC];
    wire async_on = serial_port_enable & ~sync_sel & ~sleep_mode; // [R10] [R26]
    wire sync_on = serial_port_enable & sync_sel; // [R22]
    wire transmit_enable = txsc_ctl[`ASTX_B_TRANSMIT_ENABLE];
    wire continuous_receive_enable = rxsc_ctl[`ASTX_B_CONTINUOUS_RECEIVE_ENABLE];
    wire tx9 = txsc_ctl[`ASTX_B_TX9];
    wire rx9 = rxsc_ctl[`ASTX_B_RX9];
    wire address_detect_enable = rxsc_ctl[`ASTX_B_ADDRESS_DETECT_ENABLE];
    wire high_speed_baud_select = txsc_ctl[`ASTX_B_HIGH_SPEED_BAUD_SELECT];
    wire [`ASTX_ADDR_W-1:0] addr = paddr[`ASTX_ADDR_W-1:0];
    wire acc_done = psel & penable & pready;
    wire wr_en = acc_done & pwrite & ~pslverr;
    wire rd_en = acc_done & ~pwrite & ~pslverr;
    wire [7:0] wbyte = pwdata[7:0];
    wire base_tick = (brg_cnt == 8'h00);
    wire rx_run = async_on & continuous_receive_enable; // [R14]
    wire tx_load = async_on & transmit_enable & txbuf_full & ~tx_busy; // [R1] [R11]
    wire [3:0] rx_nbits = rx9 ? `ASTX_BITS_9 : `ASTX_BITS_8;
    wire [3:0] tx_nbits = tx9 ? `ASTX_BITS_9 : `ASTX_BITS_8;
    // Stop bit is judged sixteen ticks after the last data sample, at its centre
    wire rx_word_done = (rx_state == RX_STOP) & samp_tick & (rx_tick == `ASTX_TICKS_PER_BIT);
    // Ninth bit is the last shifted in, so it sits at the top of the shifter
    wire rx_ninth = rx9 ? rx_shift[8] : 1'b0;
    wire rx_keep = ~(address_detect_enable & rx9 & ~rx_ninth); // [R20] [R27]
    wire rx_deliver = rx_word_done & rx_keep & ~rx_complete_flag;
    wire rx_overrun = rx_word_done & rx_keep & rx_complete_flag; // [R28]
    wire [7:0] rxsc_rd = {rxsc_ctl[7:3], framing_error_flag, overrun_error_flag, rx_ninth_bit_value};
    wire [7:0] txsc_rd = {txsc_ctl[7:4], 1'b0, txsc_ctl[2], ~tx_busy, txsc_ctl[0]}; // [R5]
    wire [7:0] pif_rd = {2'b00, rx_complete_flag, tx_buffer_empty_flag, 4'h0};
    wire transmit_enable_rise = wr_en & (addr == `ASTX_OFF_TXSC) & wbyte[`ASTX_B_TRANSMIT_ENABLE] & ~transmit_enable;

    // Read mux; the shift register deliberately has no decode entry
    always @* begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        case (addr)
            `ASTX_OFF_INTCTL: next_rdata[7:0] = intctl;
            `ASTX_OFF_PIFLG: next_rdata[7:0] = pif_rd;
            `ASTX_OFF_PIEN: next_rdata[7:0] = pien;
            `ASTX_OFF_PIPRI: next_rdata[7:0] = pipri;
            `ASTX_OFF_RXSC: next_rdata[7:0] = rxsc_rd;
            `ASTX_OFF_TXBUF: next_rdata[7:0] = txbuf;
            `ASTX_OFF_TXSC: next_rdata[7:0] = txsc_rd;
            `ASTX_OFF_BAUD: next_rdata[7:0] = baud;
            `ASTX_OFF_RXBUF: next_rdata[7:0] = rxbuf;
            default: next_err = 1'b1; // [R6]
        endcase
        if (paddr[31:`ASTX_ADDR_W] != 26'h000_0000) begin
            next_err = 1'b1;
        end
    end

    // APB slave: one wait state, answer in the second access cycle
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            pready <= psel & penable & ~pready;
            if (psel & penable & ~pready) begin
                pslverr <= next_err;
                prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Software-written control registers
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            intctl <= `ASTX_RST_BYTE;
            pien <= `ASTX_RST_BYTE;
            pipri <= `ASTX_RST_BYTE;
            rxsc_ctl <= `ASTX_RST_BYTE;
            txsc_ctl <= `ASTX_RST_TXSC;
            baud <= `ASTX_RST_BYTE;
            txbuf <= `ASTX_RST_BYTE;
        end else if (clk_en && wr_en) begin
            case (addr)
                `ASTX_OFF_INTCTL: intctl <= wbyte;
                `ASTX_OFF_PIEN: pien <= wbyte;
                `ASTX_OFF_PIPRI: pipri <= wbyte;
                `ASTX_OFF_RXSC: rxsc_ctl <= {wbyte[7:3], 3'b000};
                `ASTX_OFF_TXSC: txsc_ctl <= {wbyte[7:4], 1'b0, wbyte[2], 1'b0, wbyte[0]}; // [R12]
                `ASTX_OFF_BAUD: baud <= wbyte;
                `ASTX_OFF_TXBUF: txbuf <= wbyte;
                default: intctl <= intctl;
            endcase
        end
    end

    // Baud generator: base tick every baud+1 clocks, x16 sample tick after prescale
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            brg_cnt <= 8'h00;
            pre_cnt <= 2'b00;
            samp_tick <= 1'b0;
        end else if (clk_en) begin
            brg_cnt <= base_tick ? baud : brg_cnt - 8'h01;
            samp_tick <= 1'b0;
            if (base_tick) begin
                pre_cnt <= pre_cnt + 2'b01;
                // Low speed divides the x64 base by four to reach x16
                samp_tick <= high_speed_baud_select | (pre_cnt == `ASTX_LOW_PRESCALE); // [R12] [R25]
            end
        end
    end

    // Transmit flags: buffer full, buffer-empty flag with delayed clear
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            txbuf_full <= 1'b0;
            tx_buffer_empty_flag <= 1'b0;
            tx_buffer_empty_flag_clr_pend <= 1'b0;
        end else if (clk_en) begin
            tx_buffer_empty_flag_clr_pend <= wr_en & (addr == `ASTX_OFF_TXBUF);
            if (wr_en && addr == `ASTX_OFF_TXBUF) begin
                txbuf_full <= 1'b1;
            end else if (tx_load) begin
                txbuf_full <= 1'b0; // [R2]
            end
            // Set wins over the delayed clear
            if (tx_load || transmit_enable_rise) begin
                tx_buffer_empty_flag <= 1'b1; // [R2] [R3] [R7]
            end else if (tx_buffer_empty_flag_clr_pend) begin
                tx_buffer_empty_flag <= 1'b0; // [R3] [R8]
            end
        end
    end

    // Transmit shifter: frame held as {stop, ninth, data, start}, LSB out first
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_shift_register <= 11'h7ff;
            tx_bits <= 4'h0;
            tx_tick <= 4'h0;
            tx_busy <= 1'b0;
        end else if (clk_en) begin
            if (tx_load) begin
                tx_busy <= 1'b1;
                tx_tick <= 4'h0;
                tx_bits <= tx_nbits + 4'h1;
                if (tx9) begin
                    tx_shift_register <= {1'b1, txsc_ctl[`ASTX_B_TX_NINTH_BIT_VALUE], txbuf, 1'b0}; // [R9] [R24]
                end else begin
                    tx_shift_register <= {2'b11, txbuf, 1'b0}; // [R24]
                end
            end else if (tx_busy && async_on && samp_tick) begin
                tx_tick <= tx_tick + 4'h1;
                if (tx_tick == `ASTX_TICKS_PER_BIT) begin
                    tx_shift_register <= {1'b1, tx_shift_register[10:1]};
                    tx_bits <= tx_bits - 4'h1;
                    // Busy ends once the stop bit has had its full period, or at once if the serial port is disabled
                    if (tx_bits == 4'h0) begin
                        tx_busy <= 1'b0; // [R1]
                    end
                end
            end else if (!serial_port_enable) begin
                tx_busy <= 1'b0;
            end
        end
    end

    // Line input: three stages, level accepted when the last two agree
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_sync <= 3'b111;
            rx_level <= 1'b1;
        end else if (clk_en) begin
            rx_sync <= {rx_sync[1:0], rx_dt_in};
            if (rx_sync[1] == rx_sync[2]) begin
                rx_level <= rx_sync[2];
            end
        end
    end

    // Receiver: mid-bit sampling at x16; idle line is high
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_state <= RX_IDLE;
            rx_tick <= 4'h0;
            rx_bits <= 4'h0;
            rx_shift <= 9'h000;
        end else if (clk_en) begin
            if (!rx_run || (sync_on && tx_busy)) begin
                rx_state <= RX_IDLE; // [R14] [R21]
                rx_tick <= 4'h0;
            end else if (samp_tick) begin // [R13]
                rx_tick <= rx_tick + 4'h1;
                case (rx_state)
                    RX_IDLE: begin
                        if (rx_level) begin
                            rx_tick <= 4'h0;
                        end else if (rx_tick == `ASTX_MID_BIT) begin
                            rx_tick <= 4'h0;
                            rx_bits <= 4'h0;
                            rx_state <= RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        if (rx_tick == `ASTX_TICKS_PER_BIT) begin
                            // Right-align: eight-bit words land in [7:0] after shifting
                            if (rx9) begin
                                rx_shift <= {rx_level, rx_shift[8:1]}; // [R24]
                            end else begin
                                rx_shift <= {1'b0, rx_level, rx_shift[7:1]}; // [R24]
                            end
                            rx_bits <= rx_bits + 4'h1;
                            if (rx_bits == rx_nbits - 4'h1) begin
                                rx_state <= RX_STOP;
                            end
                        end
                    end
                    RX_STOP: begin
                        if (rx_tick == `ASTX_TICKS_PER_BIT) begin
                            rx_state <= RX_IDLE;
                            rx_tick <= 4'h0;
                        end
                    end
                    default: rx_state <= RX_IDLE;
                endcase
            end
        end
    end

    // Receive buffer, status and errors
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            rxbuf <= `ASTX_RST_BYTE;
            rx_ninth_bit_value <= 1'b0;
            framing_error_flag <= 1'b0;
            overrun_error_flag <= 1'b0;
            rx_complete_flag <= 1'b0;
        end else if (clk_en) begin
            if (rx_deliver) begin
                rxbuf <= rx_shift[7:0];
                rx_ninth_bit_value <= rx_ninth;
                framing_error_flag <= ~rx_level; // [R28]
                rx_complete_flag <= 1'b1; // [R15] [R27]
            end else if (rd_en && addr == `ASTX_OFF_RXBUF) begin
                rx_complete_flag <= 1'b0; // [R16]
            end
            if (!continuous_receive_enable) begin
                overrun_error_flag <= 1'b0; // [R17]
                framing_error_flag <= 1'b0; // [R17]
            end else if (rx_overrun) begin
                overrun_error_flag <= 1'b1; // [R28]
            end
        end
    end

    // Pins and interrupt requests
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_ck_out <= 1'b1;
            tx_ck_oe <= 1'b0;
            rx_dt_out <= 1'b1;
            rx_dt_oe <= 1'b0;
            irq_high <= 1'b0;
            irq_low <= 1'b0;
        end else if (clk_en) begin
            if (sync_on) begin
                tx_ck_oe <= txsc_ctl[`ASTX_B_CLOCK_SOURCE_SELECT]; // [R23]
                if (samp_tick) begin
                    tx_ck_out <= ~tx_ck_out; // [R23]
                end
                rx_dt_oe <= tx_busy; // [R21] [R22]
                rx_dt_out <= tx_shift_register[0];
            end else begin
                tx_ck_oe <= async_on;
                tx_ck_out <= tx_shift_register[0] | ~tx_busy;
                rx_dt_oe <= 1'b0;
                rx_dt_out <= 1'b1;
            end
            irq_high <= intctl[`ASTX_B_GIE] & intctl[`ASTX_B_PERIPHERAL_INTERRUPT_ENABLE] & // [R18]
                ((rx_complete_flag & pien[`ASTX_B_RX_COMPLETE_FLAG] & pipri[`ASTX_B_RX_COMPLETE_FLAG]) | // [R15] [R19]
                 (tx_buffer_empty_flag & pien[`ASTX_B_TX_BUFFER_EMPTY_FLAG] & pipri[`ASTX_B_TX_BUFFER_EMPTY_FLAG])); // [R4]
            irq_low <= intctl[`ASTX_B_GIE] & intctl[`ASTX_B_PERIPHERAL_INTERRUPT_ENABLE] & // [R18]
                ((rx_complete_flag & pien[`ASTX_B_RX_COMPLETE_FLAG] & ~pipri[`ASTX_B_RX_COMPLETE_FLAG]) | // [R15] [R19]
                 (tx_buffer_empty_flag & pien[`ASTX_B_TX_BUFFER_EMPTY_FLAG] & ~pipri[`ASTX_B_TX_BUFFER_EMPTY_FLAG])); // [R4]
        end
    end

endmodule // astx_top

// [tb/astx_assertions.sv]
// Port-level checks for the serial transceiver
`timescale 1ns/10ps
module astx_assertions (
    input wire clk_sys,
    input wire sys_rst,
    input wire clk_en,
    input wire sleep_mode,
    input wire psel,
    input wire penable,
    input wire [31:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire tx_ck_out,
    input wire irq_high,
    input wire irq_low
);
    reg last_out;
    reg [4:0] run_len;
    // Saturates so long idle stretches cannot wrap into a short run
    always @(posedge clk_sys) begin
        last_out <= tx_ck_out;
        if (sys_rst || tx_ck_out != last_out)
            run_len <= 5'h0;
        else if (run_len != 5'h1f)
            run_len <= run_len + 5'h1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    apb_answer_a: assert property (clk_en && psel && penable && !pready |=> pready)
        else $error("access not answered in time");
    apb_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    apb_error_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    data_width_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    map_hole_a: assert property (pready && (paddr > 32'h20 || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unmapped access accepted");
    map_hit_a: assert property (pready && paddr <= 32'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    bit_length_a: assert property ($changed(tx_ck_out) |-> run_len >= 5'hf)
        else $error("line bit shorter than sixteen ticks");
    sleep_hold_a: assert property (sleep_mode |=> $stable(tx_ck_out))
        else $error("line moved during sleep");
    reset_quiet_a: assert property (disable iff (!clk_en)
        sys_rst |=> !irq_high && !irq_low && !pready && tx_ck_out)
        else $error("outputs not quiet after reset");
endmodule // astx_assertions
bind astx_top astx_assertions u_astx_assertions (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .sleep_mode(sleep_mode),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_ck_out(tx_ck_out), .irq_high(irq_high), .irq_low(irq_low)
);

// [tb/astx_node.sv]
// Remote serial node: sends frames and decodes frames from the device
`timescale 1ns/10ps
module astx_node (
    input wire clk_sys,
    input wire line_in,
    output reg line_out
);
    localparam int BIT = 16;
    reg [8:0] got;
    reg got_stop;
    int frames = 0;
    int nbits = 8;
    initial line_out = 1'b1;
    task automatic send(input [8:0] w, input int n, input bit stop);
        for (int i = -1; i <= n; i++) begin
            line_out <= (i < 0) ? 1'b0 : (i == n) ? stop : w[i];
            repeat (BIT) @(posedge clk_sys);
        end
        // Rest at mark level, as the pulled-up line would
        line_out <= 1'b1;
        repeat (BIT) @(posedge clk_sys);
    endtask
    always begin
        @(negedge line_in);
        repeat (BIT / 2) @(posedge clk_sys);
        for (int i = 0; i < nbits; i++) begin
            repeat (BIT) @(posedge clk_sys);
            got[i] = line_in;
        end
        repeat (BIT) @(posedge clk_sys);
        got_stop = line_in;
        frames++;
    end
endmodule // astx_node

// [tb/astx_top_tb.sv]
// Self-checking bench for the serial transceiver
`timescale 1ns/10ps
`include "astx_map.vh"
module astx_top_tb;
    reg clk_sys = 1'b0;
    reg sys_rst = 1'b1;
    reg clk_en = 1'b1;
    reg sleep_mode = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [31:0] paddr = 32'h0;
    reg [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, tx_ck_out, tx_ck_oe, rx_dt_out, rx_dt_oe, irq_high, irq_low;
    wire line_rx;
    reg [31:0] rd;
    reg err;
    int mismatches = 0;
    int n_tests = 0;
    astx_top u_astx_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
        .sleep_mode(sleep_mode), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_ck_in(tx_ck_oe ? tx_ck_out : 1'b1), .tx_ck_out(tx_ck_out),
        .tx_ck_oe(tx_ck_oe), .rx_dt_in(rx_dt_oe ? rx_dt_out : line_rx),
        .rx_dt_out(rx_dt_out), .rx_dt_oe(rx_dt_oe), .irq_high(irq_high), .irq_low(irq_low));
    astx_node u_astx_node (.clk_sys(clk_sys), .line_in(tx_ck_out), .line_out(line_rx));
    initial forever #2.5 clk_sys = ~clk_sys;
    task automatic check(input [31:0] seen, input [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input bit w, input [5:0] a, input [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {26'h0, a};
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // Only the watchdog ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input [5:0] a, input [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rc(input [5:0] a, input [31:0] exp);
        apb(1'b0, a, 8'h0);
        check(rd, exp);
    endtask
    task automatic wait_frames(input int k);
        int n;
        n = 0;
        while (u_astx_node.frames < k && n < 5000) begin
            n++;
            @(posedge clk_sys);
        end
        if (n == 5000)
            mismatches++;
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        wrap_up;
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i <= 8; i++) begin
            rc(6'(i * 4), i == 6 ? 32'h2 : 32'h0);
        end
        wr(`ASTX_OFF_RXBUF, 8'hff);
        rc(`ASTX_OFF_RXBUF, 32'h0);
        apb(1'b0, 6'h24, 8'h0);
        check(err, 1'b1);
        sleep_mode <= 1'b1;
        repeat (4) @(posedge clk_sys);
        sleep_mode <= 1'b0;
        clk_en <= 1'b0;
        repeat (3) @(posedge clk_sys);
        clk_en <= 1'b1;
        wr(`ASTX_OFF_BAUD, 8'h0);
        wr(`ASTX_OFF_RXSC, 8'h80);
        wr(`ASTX_OFF_TXSC, 8'h24);
        rc(`ASTX_OFF_PIFLG, 32'h10);
        // Second word waits in the holding buffer behind the first
        wr(`ASTX_OFF_TXBUF, 8'ha5);
        wr(`ASTX_OFF_TXBUF, 8'h3c);
        wr(`ASTX_OFF_PIFLG, 8'hff);
        rc(`ASTX_OFF_PIFLG, 32'h0);
        rc(`ASTX_OFF_TXSC, 32'h24);
        wait_frames(1);
        check(u_astx_node.got[7:0], 8'ha5);
        rc(`ASTX_OFF_PIFLG, 32'h0);
        wait_frames(2);
        check(u_astx_node.got[7:0], 8'h3c);
        wr(`ASTX_OFF_PIEN, 8'h10);
        wr(`ASTX_OFF_INTCTL, 8'h40);
        @(posedge clk_sys);
        check(irq_low, 1'b0);
        wr(`ASTX_OFF_INTCTL, 8'hc0);
        @(posedge clk_sys);
        check(irq_low, 1'b1);
        rc(`ASTX_OFF_TXSC, 32'h26);
        rc(`ASTX_OFF_PIFLG, 32'h10);
        u_astx_node.nbits = 9;
        wr(`ASTX_OFF_TXSC, 8'h65);
        wr(`ASTX_OFF_TXBUF, 8'h0f);
        wait_frames(3);
        check(u_astx_node.got, 9'h10f);
        wr(`ASTX_OFF_PIEN, 8'h20);
        wr(`ASTX_OFF_PIPRI, 8'h20);
        wr(`ASTX_OFF_RXSC, 8'h90);
        u_astx_node.send(9'h05a, 8, 1'b1);
        @(posedge clk_sys);
        check({irq_high, irq_low}, 2'h2);
        rc(`ASTX_OFF_RXSC, 32'h90);
        rc(`ASTX_OFF_RXBUF, 32'h5a);
        rc(`ASTX_OFF_PIFLG, 32'h10);
        u_astx_node.send(9'h0c3, 8, 1'b0);
        rc(`ASTX_OFF_RXSC, 32'h94);
        rc(`ASTX_OFF_RXBUF, 32'hc3);
        wr(`ASTX_OFF_RXSC, 8'h80);
        rc(`ASTX_OFF_RXSC, 32'h80);
        u_astx_node.send(9'h077, 8, 1'b1);
        rc(`ASTX_OFF_PIFLG, 32'h10);
        wr(`ASTX_OFF_RXSC, 8'h90);
        sleep_mode <= 1'b1;
        u_astx_node.send(9'h077, 8, 1'b1);
        sleep_mode <= 1'b0;
        rc(`ASTX_OFF_PIFLG, 32'h10);
        u_astx_node.send(9'h011, 8, 1'b1);
        u_astx_node.send(9'h022, 8, 1'b1);
        rc(`ASTX_OFF_RXSC, 32'h92);
        rc(`ASTX_OFF_RXBUF, 32'h11);
        // Overrun stays latched until continuous receive is switched off
        wr(`ASTX_OFF_RXSC, 8'h80);
        wr(`ASTX_OFF_RXSC, 8'hd8);
        u_astx_node.send(9'h033, 9, 1'b1);
        rc(`ASTX_OFF_PIFLG, 32'h10);
        u_astx_node.send(9'h1a7, 9, 1'b1);
        rc(`ASTX_OFF_RXSC, 32'hd9);
        rc(`ASTX_OFF_RXBUF, 32'ha7);
        wr(`ASTX_OFF_RXSC, 8'hd0);
        u_astx_node.send(9'h033, 9, 1'b1);
        rc(`ASTX_OFF_RXBUF, 32'h33);
        wr(`ASTX_OFF_BAUD, 8'hff);
        wr(`ASTX_OFF_TXSC, 8'h90);
        @(posedge clk_sys);
        check(tx_ck_oe, 1'b1);
        wr(`ASTX_OFF_TXSC, 8'h10);
        @(posedge clk_sys);
        check(tx_ck_oe, 1'b0);
        wrap_up;
    end
endmodule // astx_top_tb
